// ---- bench/twes_master.sv ----
// Behavioural two-wire bus master: it makes the bus clock and pulls data low.
// Assumes a pull-up on the data wire, resolved by the bench.
`timescale 1ns/1ps
module twes_master (
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe
);
   localparam time Q = 40ns;

   // The clock stands high between frames, so the link logic sees no edges then.
   initial
   begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end

   task automatic start_c;
      o_sda_oe = 1'b0;
      #Q o_scl = 1'b1;
      #Q o_sda_oe = 1'b1;
      #Q o_scl = 1'b0;
      #Q;
   endtask

   task automatic stop_c;
      o_sda_oe = 1'b1;
      #Q o_scl = 1'b1;
      #Q o_sda_oe = 1'b0;
      #(2 * Q);
   endtask

   task automatic bit_c(input logic b, output logic r);
      o_sda_oe = ~b;
      #Q o_scl = 1'b1;
      #Q r = i_sda;
      #Q o_scl = 1'b0;
      #Q;
   endtask

   task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] r);
      logic b;
      r = 8'h00;
      for (int i = 0; i < n; i++)
      begin
         bit_c(d[7 - i], b);
         r = {r[6:0], b};
      end
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic [7:0] r;
      logic b;
      xfer(d, 8, r);
      bit_c(1'b1, b);
      ack = ~b;
   endtask

   task automatic rd_byte(input logic more, output logic [7:0] d);
      logic b;
      xfer(8'hff, 8, d);
      bit_c(~more, b);
   endtask
endmodule

// ---- bench/two_wire_eeprom_slave_port_bench.sv ----
// Self-checking bench for the two-wire EEPROM slave port.
// Assumes the bus master model in twes_master drives the bus; select and protect pins
// are driven here and only change between frames.
`timescale 1ns/1ps
module two_wire_eeprom_slave_port_bench;
   localparam logic [3:0] DEV = 4'h5; // Arbitrary type code.
   localparam int WC = 80;
   logic i_clk_sys, i_rst_n, i_wp, sda_w, scl, m_oe, o_sda_out, o_sda_oe, o_busy;
   logic [1:0] sel_r;
   logic [7:0] o_ctrl;
   logic [16:0] lfsr_r = 17'h18020;
   logic [7:0] pg [64];
   int error_cnt = 0, tests_run = 0, cyc = 0, busy_cnt = 0, last_len = 0;

   assign sda_w = (m_oe === 1'b1) ? 1'b0 : ((o_sda_oe === 1'b1) ? o_sda_out : 1'b1);

   twes_port #(.DEV_TYPE(DEV), .WRITE_CYCLES(WC)) u_dut (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_w),
      .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_select_in_zero(sel_r[0]),
      .i_select_in_one(sel_r[1]), .i_wp(i_wp), .o_busy(o_busy), .o_ctrl(o_ctrl));
   twes_master u_mst (.i_sda(sda_w), .o_scl(scl), .o_sda_oe(m_oe));

   initial
   begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end

   function automatic logic [7:0] adr(input logic rw);
      return {DEV, 1'b0, sel_r, rw};
   endfunction

   task automatic rnd(output logic [7:0] v);
      repeat (8) lfsr_r = {lfsr_r[15:0], lfsr_r[16] ^ lfsr_r[13]};
      v = lfsr_r[7:0];
   endtask

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up;
      if (error_cnt == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic tick;
      @(posedge i_clk_sys);
      #1;
   endtask

   task automatic header(input logic [15:0] a);
      logic ack;
      u_mst.start_c();
      u_mst.wr_byte(adr(1'b0), ack);
      check("addr_ack", ack, 1'b1);
      u_mst.wr_byte(a[15:8], ack);
      check("wa1_ack", ack, 1'b1);
      u_mst.wr_byte(a[7:0], ack);
      check("wa0_ack", ack, 1'b1);
   endtask

   task automatic cr_write(input logic [7:0] v);
      logic ack;
      header(16'hffff);
      u_mst.wr_byte(v, ack);
      check("cr_ack", ack, 1'b1);
      u_mst.stop_c();
      repeat (5) tick();
   endtask

   task automatic read_seq(input logic [15:0] a, input int n);
      logic ack;
      logic [7:0] d;
      header(a);
      u_mst.start_c();
      u_mst.wr_byte(adr(1'b1), ack);
      check("rd_ack", ack, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         u_mst.rd_byte(i != n - 1, d);
         check("rdata", d, pg[6'(a[5:0] + i)]);
      end
      check("rel_nack", o_sda_oe, 1'b0);
      u_mst.stop_c();
   endtask

   task automatic wait_busy(input logic poll);
      int i;
      logic ack;
      for (i = 0; i < 100 && o_busy !== 1'b1; i++) tick();
      check("busy_rise", o_busy, 1'b1);
      if (poll)
      begin
         u_mst.start_c();
         u_mst.wr_byte(adr(1'b0), ack);
         u_mst.stop_c();
         check("poll_busy", ack, 1'b0);
      end
      for (i = 0; i < WC + 100 && o_busy !== 1'b0; i++) tick();
      tick();
      check("busy_len", 16'(last_len), 16'(WC));
      if (poll)
      begin
         u_mst.start_c();
         u_mst.wr_byte(adr(1'b0), ack);
         u_mst.stop_c();
         check("poll_done", ack, 1'b1);
      end
   endtask

   // The monitor watches the data line every cycle and cuts a hang short.
   always @(posedge i_clk_sys)
   begin
      cyc <= cyc + 1;
      busy_cnt <= (o_busy === 1'b1) ? busy_cnt + 1 : 0;
      if (o_busy !== 1'b1 && busy_cnt != 0)
         last_len <= busy_cnt;
      if (o_busy === 1'b1)
         check("oe_busy", o_sda_oe, 1'b0);
      if (o_sda_oe === 1'b1)
         check("sda_out", o_sda_out, 1'b0);
      if (cyc == 20000)
      begin
         error_cnt++;
         wrap_up();
      end
   end

   initial
   begin
      logic [7:0] v;
      logic ack;
      logic [8:0] page;
      logic [7:0] flip [5];
      flip = '{8'h80, 8'h08, 8'h04, 8'h02, 8'h00};
      i_rst_n = 1'b1;
      i_wp = 1'b0;
      sel_r = 2'b00;
      // The bus-side flops clear on a falling reset edge, so give them a real one.
      @(posedge i_clk_sys);
      i_rst_n <= 1'b0;
      repeat (10) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      repeat (3) tick();
      check("busy_rst", o_busy, 1'b0);
      check("ctrl_rst", o_ctrl, twes_pkg::CR_RST);
      for (int j = 0; j < 4; j++)
      begin
         @(posedge i_clk_sys);
         sel_r <= 2'(j);
         tick();
         for (int i = 0; i < 5; i++)
         begin
            u_mst.start_c();
            u_mst.wr_byte(adr(1'b0) ^ flip[i], ack);
            u_mst.stop_c();
            check("sel_ack", ack, i == 4);
         end
      end
      rnd(v);
      @(posedge i_clk_sys);
      sel_r <= v[1:0];
      page[8:1] = v;
      rnd(v);
      page[0] = v[0];
      header({1'b0, page, 6'h20});
      u_mst.wr_byte(8'h5a, ack);
      check("wel_nack", ack, 1'b0);
      u_mst.stop_c();
      repeat (20) tick();
      check("busy_wel", o_busy, 1'b0);
      cr_write(twes_pkg::CR_CMD_WEL_SET);
      check("wel_set", o_ctrl[twes_pkg::CR_WRITE_ENABLE_LATCH], 1'b1);
      check("busy_wset", o_busy, 1'b0);
      header({1'b0, page, 6'h20});
      for (int i = 0; i < 66; i++)
      begin
         rnd(v);
         pg[6'(32 + i)] = v;
         u_mst.wr_byte(v, ack);
         check("page_ack", ack, 1'b1);
      end
      check("busy_pre", o_busy, 1'b0);
      u_mst.stop_c();
      wait_busy(1'b1);
      read_seq({1'b0, page, 6'h00}, 64);
      for (int i = 0; i < 2; i++)
      begin
         // Pass 0 breaks the first byte; pass 1 breaks the byte after an acknowledged one.
         header({1'b0, page, 6'h05});
         if (i == 1)
         begin
            u_mst.wr_byte(~pg[5], ack);
            check("abort_ack", ack, 1'b1);
         end
         u_mst.xfer(~pg[6'(5 + i)], 3, v);
         u_mst.stop_c();
         repeat (20) tick();
         check("busy_abort", o_busy, 1'b0);
      end
      read_seq({1'b0, page, 6'h05}, 1);
      cr_write(twes_pkg::CR_CMD_RWEL_SET);
      cr_write(8'h98);
      wait_busy(1'b0);
      check("ctrl_set", {o_ctrl[7], o_ctrl[4:3]}, 3'b111);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge i_clk_sys);
         i_wp <= (i == 0);
         cr_write(twes_pkg::CR_CMD_RWEL_SET);
         cr_write(8'h40);
         wait_busy(1'b0);
         check("ctrl_wp", {o_ctrl[7], o_ctrl[4:3]}, (i == 0) ? 3'b111 : 3'b000);
      end
      cr_write(twes_pkg::CR_CMD_CLEAR);
      check("wel_clr", o_ctrl[twes_pkg::CR_WRITE_ENABLE_LATCH], 1'b0);
      // The last register write left 42h; clearing drops only the two latches.
      header(twes_pkg::CR_ADDR);
      u_mst.start_c();
      u_mst.wr_byte(adr(1'b1), ack);
      check("cr_rd_ack", ack, 1'b1);
      u_mst.rd_byte(1'b0, v);
      u_mst.stop_c();
      check("cr_read", v, 8'h40);
      wrap_up();
   end
endmodule

// ---- shared/twes_pkg.sv ----
// Constants and state types for the two-wire EEPROM slave port.
// Assumes one sys-clock domain and one domain clocked by the bus clock pin.
package twes_pkg;

   localparam int MEM_AW = 15;
   localparam int PAGE_BYTES = 64;
   localparam int PAGES = 512;

   localparam logic [15:0] CR_ADDR = 16'hffff;
   localparam logic [5:0] CR_BUF_IDX = 6'h3f;
   localparam int CR_PROTECT_ENABLE_BIT = 7;
   localparam int CR_BP_HI = 4;
   localparam int CR_BP_LO = 3;
   localparam int CR_REG_WRITE_LATCH = 2;
   localparam int CR_WRITE_ENABLE_LATCH = 1;
   localparam logic [7:0] CR_RST = 8'h60;
   localparam logic [7:0] CR_CMD_WEL_SET = 8'h02;
   localparam logic [7:0] CR_CMD_RWEL_SET = 8'h06;
   localparam logic [7:0] CR_CMD_CLEAR = 8'h00;

   localparam logic [3:0] BIT_FIRST = 4'h1;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;

   localparam int WRITE_CYCLES_DEF = 1000;
   localparam int BUSY_W = 16;

   typedef enum logic [2:0] {
      LS_IDLE = 3'b000,
      LS_ADDR = 3'b001,
      LS_AB1 = 3'b010,
      LS_AB0 = 3'b011,
      LS_WDATA = 3'b100,
      LS_RDATA = 3'b101
   } twes_lst_e;

   typedef struct packed {
      twes_lst_e st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic [15:0] addr;
      logic [63:0] mask;
      logic ack;
      logic rw;
      logic cr;
      logic armed;
      logic start_seen;
      logic busy_s1;
      logic busy_s2;
      logic wel_s1;
      logic wel_s2;
      logic [1:0] sel_s1;
      logic [1:0] sel_s2;
   } twes_link_s;

   typedef struct packed {
      logic stop_s1;
      logic stop_s2;
      logic stop_s3;
      logic armed_s1;
      logic armed_s2;
      logic wp_s1;
      logic wp_s2;
      logic busy;
      logic [BUSY_W-1:0] cnt;
      logic [8:0] page;
      logic [63:0] wmask;
      logic [6:0] widx;
      logic [7:0] ctrl;
   } twes_sys_s;

endpackage

// ---- src/twes_port.sv ----
// Two-wire slave port of a 32 KB EEPROM with a control register at the top address.
// Assumes the bus clock pin clocks the link logic and the system clock runs the array.
// Pull-downs on select and write-protect pins live in the pads, outside this logic.
`timescale 1ns/1ps
module twes_port #(
   parameter logic [3:0] DEV_TYPE = 4'h5, // Arbitrary value; set to the part's type code.
   parameter int WRITE_CYCLES = twes_pkg::WRITE_CYCLES_DEF
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic i_select_in_zero,
   input wire logic i_select_in_one,
   input wire logic i_wp,
   output logic o_busy,
   output logic [7:0] o_ctrl
);

   twes_pkg::twes_link_s l_r;
   twes_pkg::twes_link_s l_nxt;
   twes_pkg::twes_sys_s s_r;
   twes_pkg::twes_sys_s s_nxt;

   logic [7:0] mem_r [0:(1 << twes_pkg::MEM_AW) - 1];
   logic [7:0] buf_r [0:twes_pkg::PAGE_BYTES - 1];
   logic start_tgl_r;
   logic stop_tgl_r;
   logic oe_r;
   logic start_pend;
   logic [7:0] rx;
   logic addr_match;
   logic wr_accept;
   logic buf_we;
   logic stop_evt;
   logic mem_we;
   logic [7:0] cr_cmd;
   logic [7:0] cr_new;
   logic [15:0] rd_next;
   localparam logic [twes_pkg::BUSY_W-1:0] BUSY_INIT = twes_pkg::BUSY_W'(WRITE_CYCLES - 1);

   // Array and control register are only written while the link is idle or refusing,
   // so the link may read them without a crossing.
   function automatic logic [7:0] rd_byte(input logic [15:0] a);
      logic [7:0] v;
      v = mem_r[a[twes_pkg::MEM_AW-1:0]];
      if (a == twes_pkg::CR_ADDR)
      begin
         v = s_r.ctrl;
      end
      return v;
   endfunction

   // Start and stop are seen on data-line edges while the clock is high. The toggles
   // are read a full bus half-period later, which the hold time of the protocol covers.
   always_ff @(negedge i_sda or negedge i_rst_n)
   begin
      if (!i_rst_n)
         start_tgl_r <= 1'b0;
      else if (i_scl)
         start_tgl_r <= ~start_tgl_r;
   end

   always_ff @(posedge i_sda or negedge i_rst_n)
   begin
      if (!i_rst_n)
         stop_tgl_r <= 1'b0;
      else if (i_scl)
         stop_tgl_r <= ~stop_tgl_r;
   end

   assign start_pend = start_tgl_r != l_r.start_seen;
   assign rx = {l_r.sh[6:0], i_sda};
   assign addr_match = rx[7:4] == DEV_TYPE && rx[3] == 1'b0 &&
      rx[2:1] == l_r.sel_s2 && !l_r.busy_s2;
   assign rd_next = {1'b0, l_r.addr[14:0] + 15'h0001};

   // A control-register byte is taken only once per transfer; the enable-latch set
   // and clear commands pass even with the latch clear, or it could never be set.
   always_comb
   begin
      if (l_r.cr)
         wr_accept = !(|l_r.mask) && (l_r.wel_s2 || rx == twes_pkg::CR_CMD_WEL_SET ||
            rx == twes_pkg::CR_CMD_CLEAR);
      else
         wr_accept = l_r.wel_s2;
   end

   always_comb
   begin
      l_nxt = l_r;
      buf_we = 1'b0;
      l_nxt.busy_s1 = s_r.busy;
      l_nxt.busy_s2 = l_r.busy_s1;
      l_nxt.wel_s1 = s_r.ctrl[twes_pkg::CR_WRITE_ENABLE_LATCH];
      l_nxt.wel_s2 = l_r.wel_s1;
      l_nxt.sel_s1 = {i_select_in_one, i_select_in_zero};
      l_nxt.sel_s2 = l_r.sel_s1;
      if (start_pend)
      begin
         l_nxt.start_seen = start_tgl_r;
         l_nxt.st = twes_pkg::LS_ADDR;
         l_nxt.cnt = twes_pkg::BIT_FIRST;
         l_nxt.sh = {7'h00, i_sda};
         l_nxt.ack = 1'b0;
         l_nxt.armed = 1'b0;
      end
      else if (l_r.st != twes_pkg::LS_IDLE)
      begin
         if (l_r.cnt < twes_pkg::BIT_ACK)
         begin
            l_nxt.cnt = l_r.cnt + 4'h1;
            if (l_r.st == twes_pkg::LS_RDATA)
               l_nxt.tx = {l_r.tx[6:0], 1'b0};
            else
               l_nxt.sh = rx;
            // The rising clock edge of a stop samples one bit, so a byte counts as
            // broken only from its second bit on.
            if (l_r.st == twes_pkg::LS_WDATA && l_r.cnt == twes_pkg::BIT_FIRST)
               l_nxt.armed = 1'b0;
            if (l_r.cnt == twes_pkg::BIT_LAST)
            begin
               case (l_r.st)
                  twes_pkg::LS_ADDR:
                  begin
                     l_nxt.ack = addr_match;
                     l_nxt.rw = i_sda;
                     if (!addr_match)
                        l_nxt.st = twes_pkg::LS_IDLE;
                  end
                  twes_pkg::LS_AB1, twes_pkg::LS_AB0:
                     l_nxt.ack = 1'b1;
                  twes_pkg::LS_WDATA:
                  begin
                     l_nxt.ack = wr_accept;
                     if (!wr_accept)
                        l_nxt.st = twes_pkg::LS_IDLE;
                  end
                  default:
                     l_nxt.ack = 1'b0;
               endcase
            end
         end
         else
         begin
            l_nxt.cnt = 4'h0;
            l_nxt.ack = 1'b0;
            case (l_r.st)
               twes_pkg::LS_ADDR:
               begin
                  if (l_r.rw)
                  begin
                     l_nxt.st = twes_pkg::LS_RDATA;
                     l_nxt.tx = rd_byte(l_r.addr);
                  end
                  else
                     l_nxt.st = twes_pkg::LS_AB1;
               end
               twes_pkg::LS_AB1:
               begin
                  l_nxt.addr[15:8] = l_r.sh;
                  l_nxt.st = twes_pkg::LS_AB0;
               end
               twes_pkg::LS_AB0:
               begin
                  l_nxt.addr[7:0] = l_r.sh;
                  l_nxt.st = twes_pkg::LS_WDATA;
                  l_nxt.mask = 64'h0;
                  l_nxt.cr = {l_r.addr[15:8], l_r.sh} == twes_pkg::CR_ADDR;
               end
               twes_pkg::LS_WDATA:
               begin
                  buf_we = 1'b1;
                  l_nxt.mask[l_r.addr[5:0]] = 1'b1;
                  l_nxt.armed = 1'b1;
                  if (!l_r.cr)
                     l_nxt.addr[5:0] = l_r.addr[5:0] + 6'h01;
               end
               twes_pkg::LS_RDATA:
               begin
                  if (!i_sda)
                  begin
                     l_nxt.addr = rd_next;
                     l_nxt.tx = rd_byte(rd_next);
                  end
                  else
                     l_nxt.st = twes_pkg::LS_IDLE;
               end
               default:
                  l_nxt.st = twes_pkg::LS_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge i_scl or negedge i_rst_n)
   begin
      if (!i_rst_n)
         l_r <= '0;
      else
         l_r <= l_nxt;
   end

   always_ff @(posedge i_scl)
   begin
      if (buf_we)
         buf_r[l_r.addr[5:0]] <= l_r.sh;
   end

   // The line changes only after the clock falls, never while it is high.
   always_ff @(negedge i_scl or negedge i_rst_n)
   begin
      if (!i_rst_n)
         oe_r <= 1'b0;
      else
         oe_r <= !l_r.busy_s2 && ((l_r.ack && l_r.cnt == twes_pkg::BIT_ACK) ||
            (l_r.st == twes_pkg::LS_RDATA && l_r.cnt < twes_pkg::BIT_ACK &&
            !l_r.tx[7]));
   end

   assign o_sda_out = 1'b0;
   assign o_sda_oe = oe_r;
   assign o_busy = s_r.busy;
   assign o_ctrl = s_r.ctrl;

   assign stop_evt = s_r.stop_s2 ^ s_r.stop_s3;
   assign mem_we = s_r.busy && !s_r.widx[6] && s_r.wmask[s_r.widx[5:0]];
   assign cr_cmd = buf_r[twes_pkg::CR_BUF_IDX];

   always_comb
   begin
      cr_new = cr_cmd;
      cr_new[twes_pkg::CR_REG_WRITE_LATCH] = 1'b0;
      cr_new[twes_pkg::CR_WRITE_ENABLE_LATCH] = 1'b1;
      if (s_r.wp_s2 && s_r.ctrl[twes_pkg::CR_PROTECT_ENABLE_BIT])
      begin
         cr_new[twes_pkg::CR_PROTECT_ENABLE_BIT] = 1'b1;
         cr_new[twes_pkg::CR_BP_HI:twes_pkg::CR_BP_LO] =
            s_r.ctrl[twes_pkg::CR_BP_HI:twes_pkg::CR_BP_LO];
      end
   end

   // Buffered bytes, address and mask stay frozen from the last acknowledge until
   // the next start, and the link refuses traffic while the cycle runs.
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.stop_s1 = stop_tgl_r;
      s_nxt.stop_s2 = s_r.stop_s1;
      s_nxt.stop_s3 = s_r.stop_s2;
      s_nxt.armed_s1 = l_r.armed;
      s_nxt.armed_s2 = s_r.armed_s1;
      s_nxt.wp_s1 = i_wp;
      s_nxt.wp_s2 = s_r.wp_s1;
      if (s_r.busy)
      begin
         if (!s_r.widx[6])
            s_nxt.widx = s_r.widx + 7'h01;
         if (s_r.cnt == '0)
            s_nxt.busy = 1'b0;
         else
            s_nxt.cnt = s_r.cnt - 16'h0001;
      end
      else if (stop_evt && s_r.armed_s2)
      begin
         if (!l_r.cr)
         begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt = BUSY_INIT;
            s_nxt.page = l_r.addr[14:6];
            s_nxt.wmask = l_r.mask;
            s_nxt.widx = 7'h00;
         end
         else if (cr_cmd == twes_pkg::CR_CMD_WEL_SET)
            s_nxt.ctrl[twes_pkg::CR_WRITE_ENABLE_LATCH] = 1'b1;
         else if (cr_cmd == twes_pkg::CR_CMD_CLEAR)
         begin
            s_nxt.ctrl[twes_pkg::CR_WRITE_ENABLE_LATCH] = 1'b0;
            s_nxt.ctrl[twes_pkg::CR_REG_WRITE_LATCH] = 1'b0;
         end
         else if (cr_cmd == twes_pkg::CR_CMD_RWEL_SET &&
            s_r.ctrl[twes_pkg::CR_WRITE_ENABLE_LATCH])
            s_nxt.ctrl[twes_pkg::CR_REG_WRITE_LATCH] = 1'b1;
         else if (s_r.ctrl[twes_pkg::CR_WRITE_ENABLE_LATCH] &&
            s_r.ctrl[twes_pkg::CR_REG_WRITE_LATCH])
         begin
            s_nxt.ctrl = cr_new;
            s_nxt.busy = 1'b1;
            s_nxt.cnt = BUSY_INIT;
            s_nxt.wmask = 64'h0;
            s_nxt.widx = 7'h00;
         end
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         s_r <= '0;
         s_r.ctrl <= twes_pkg::CR_RST;
      end
      else
         s_r <= s_nxt;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (mem_we)
         mem_r[{s_r.page, s_r.widx[5:0]}] <= buf_r[s_r.widx[5:0]];
   end

   property link_p(logic c, logic e);
      @(posedge i_scl) disable iff (!i_rst_n) c |=> e;
   endproperty

   start_seen_a: assert property (link_p(start_pend,
      l_r.st == twes_pkg::LS_ADDR && l_r.cnt == twes_pkg::BIT_FIRST))
      else $error("start did not restart the address byte");

   addr_nack_a: assert property (link_p(!start_pend && l_r.st == twes_pkg::LS_ADDR &&
      l_r.cnt == twes_pkg::BIT_LAST && rx[7:4] != DEV_TYPE,
      l_r.st == twes_pkg::LS_IDLE && !l_r.ack))
      else $error("mismatched address was not refused");

   busy_nack_a: assert property (link_p(!start_pend && l_r.st == twes_pkg::LS_ADDR &&
      l_r.cnt == twes_pkg::BIT_LAST && l_r.busy_s2, !l_r.ack))
      else $error("address acknowledged while busy");

   wel_gate_a: assert property (link_p(!start_pend && l_r.st == twes_pkg::LS_WDATA &&
      l_r.cnt == twes_pkg::BIT_LAST && !l_r.cr && !l_r.wel_s2, !l_r.ack))
      else $error("data acknowledged with write latch clear");

   ack_release_a: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      l_r.ack && l_r.cnt == twes_pkg::BIT_ACK && !start_pend |=> !l_r.ack && l_r.cnt == 4'h0)
      else $error("acknowledge not released after ninth clock");

   page_wrap_a: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      !start_pend && l_r.st == twes_pkg::LS_WDATA && l_r.cnt == twes_pkg::BIT_ACK && !l_r.cr
      |=> l_r.addr[15:6] == $past(l_r.addr[15:6]) &&
      l_r.addr[5:0] == $past(l_r.addr[5:0]) + 6'h01)
      else $error("page offset did not wrap inside the page");

   read_stop_a: assert property (link_p(!start_pend && l_r.st == twes_pkg::LS_RDATA &&
      l_r.cnt == twes_pkg::BIT_ACK && i_sda, l_r.st == twes_pkg::LS_IDLE))
      else $error("read continued without acknowledge");

   abort_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !s_r.busy && stop_evt && !s_r.armed_s2 |=> !s_r.busy && s_r.ctrl == $past(s_r.ctrl))
      else $error("broken write was committed");

   busy_count_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_r.busy && s_r.cnt != '0 |=> s_r.busy && s_r.cnt == $past(s_r.cnt) - 16'h0001)
      else $error("write cycle count skipped");

   protect_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_r.wp_s2 && s_r.ctrl[twes_pkg::CR_PROTECT_ENABLE_BIT] |=>
      s_r.ctrl[twes_pkg::CR_PROTECT_ENABLE_BIT] &&
      s_r.ctrl[twes_pkg::CR_BP_HI:twes_pkg::CR_BP_LO] ==
      $past(s_r.ctrl[twes_pkg::CR_BP_HI:twes_pkg::CR_BP_LO]))
      else $error("protected control bits changed");

   page_commit_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(s_r.busy) && s_r.wmask != 64'h0);
   addr_nack_c: cover property (@(posedge i_scl) disable iff (!i_rst_n)
      l_r.st == twes_pkg::LS_ADDR && l_r.cnt == twes_pkg::BIT_LAST && !addr_match);
   read_more_c: cover property (@(posedge i_scl) disable iff (!i_rst_n)
      l_r.st == twes_pkg::LS_RDATA && l_r.cnt == twes_pkg::BIT_ACK && !i_sda);
   poll_busy_c: cover property (@(posedge i_scl) disable iff (!i_rst_n)
      l_r.st == twes_pkg::LS_ADDR && l_r.cnt == twes_pkg::BIT_LAST && l_r.busy_s2);

endmodule
